// ### logic/rbw_pkg.sv
// Constants for the relay board heartbeat watchdog.
// Assumes a 25 MHz core clock and a 32-bit AXI4-Lite register port.
package rbw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam longint RBW_CLK_HZ = 25000000;
  localparam longint RBW_HB_TIMEOUT_S = 30;
  localparam logic [29:0] RBW_TIMEOUT_CYC =
    30'(RBW_CLK_HZ * RBW_HB_TIMEOUT_S);
  localparam int RBW_CNT_W = 30;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [4:0] RBW_CTRL_OFS = 5'h00;
  localparam logic [4:0] RBW_STAT_OFS = 5'h04;
  localparam logic [4:0] RBW_IRQ_STAT_OFS = 5'h08;
  localparam logic [4:0] RBW_IRQ_CLR_OFS = 5'h0C;
  localparam logic [4:0] RBW_IRQ_EN_OFS = 5'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Control bits; the status register reuses them, with bit 0 the trip flag.
  localparam int RBW_HB_BIT = 0;
  localparam int RBW_CHAMBER_BIT = 1;
  localparam int RBW_PERM_BIT = 2;
  localparam int RBW_SPAN_BIT = 3;
  localparam int RBW_CAL_BIT = 4;
  localparam int RBW_UV_BIT = 5;
  localparam int RBW_PUMP_BIT = 6;
  localparam int RBW_TRIP_BIT = 0;
  localparam int RBW_CTRL_W = 7;

  // Interrupt events.
  localparam int RBW_EV_TRIP = 0;
  localparam int RBW_EV_RESUME = 1;
  localparam int RBW_EV_W = 2;

  localparam logic [6:0] RBW_CTRL_RST = 7'h00;
  localparam logic [1:0] RBW_RESP_OKAY = 2'h0;
  localparam logic [1:0] RBW_RESP_SLVERR = 2'h2;

endpackage

// ### logic/rbw_watchdog.sv
// Relay board heartbeat watchdog with AXI4-Lite registers.
// Assumes the host toggles the heartbeat bit over the bus; sys_rst is sync.
//
// Operation
// R01: Host toggles heartbeat every three seconds.
// R02: Thirty seconds without toggle closes all valves.
// R03: Timeout also switches off UV and heaters.
// R04: Sample pump keeps running after timeout.
// R05: Heater indicators lit exactly while heater driven.
// R06: Zero/span indicator lit on span path.
// R07: Sample/cal indicator lit on calibration path.
// R08: Host commands arrive over the serial register bus.
// R09: Toggle restarts count; trip holds until toggling.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module rbw_watchdog
  import rbw_pkg::*;
#(
  parameter logic [29:0] TIMEOUT_CYC = RBW_TIMEOUT_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [4:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic heartbeat_indicator,
  output logic chamber_heater_on,
  output logic perm_heater_on,
  output logic zero_span_valve_drv,
  output logic sample_cal_valve_drv,
  output logic uv_source_on,
  output logic pump_on,
  output logic chamber_heat_indicator,
  output logic perm_tube_heat_indicator,
  output logic zero_span_valve_indicator,
  output logic sample_cal_valve_indicator,
  output logic watchdog_tripped,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  typedef struct packed {
    logic aw_have;
    logic [4:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic w_strb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [RBW_CTRL_W-1:0] ctrl;
    logic hb_prev;
    logic [RBW_CNT_W-1:0] count;
    logic tripped;
    logic [RBW_CTRL_W-1:0] drive;
    logic [RBW_EV_W-1:0] ev_stat;
    logic [RBW_EV_W-1:0] ev_en;
    logic irq;
  } rbw_state_type;

  localparam rbw_state_type RBW_STATE_RST = '{
    aw_addr: 5'h00, w_data: 32'h0000_0000, rdata: 32'h0000_0000,
    bresp: RBW_RESP_OKAY, rresp: RBW_RESP_OKAY, ctrl: RBW_CTRL_RST,
    count: 30'h0, drive: RBW_CTRL_RST, ev_stat: 2'h0,
    ev_en: 2'h0, default: 1'b0
  };

  rbw_state_type q, d;

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  logic hb_changed;
  logic [RBW_EV_W-1:0] ev_set;
  logic [RBW_EV_W-1:0] ev_clr;
  logic [RBW_CTRL_W-1:0] stat_word;

  always_comb begin
    d = q;
    ev_set = '0;
    ev_clr = '0;
    stat_word = q.drive;
    stat_word[RBW_TRIP_BIT] = q.tripped;

    // Write address and data are latched separately, in either order.
    if (s_axi_awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb0 = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_have && q.w_have && !q.bvalid) begin // R08
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RBW_RESP_OKAY;
      case (q.aw_addr)
        RBW_CTRL_OFS: begin
          if (q.w_strb0) begin
            d.ctrl = q.w_data[RBW_CTRL_W-1:0];
          end
        end
        RBW_IRQ_CLR_OFS: begin
          if (q.w_strb0) begin
            ev_clr = q.w_data[RBW_EV_W-1:0];
          end
        end
        RBW_IRQ_EN_OFS: begin
          if (q.w_strb0) begin
            d.ev_en = q.w_data[RBW_EV_W-1:0];
          end
        end
        RBW_STAT_OFS, RBW_IRQ_STAT_OFS: begin
          d.bresp = RBW_RESP_OKAY;
        end
        default: begin
          d.bresp = RBW_RESP_SLVERR;
        end
      endcase
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready = !d.w_have && !d.bvalid;

    // Reads answer one cycle after the address is taken.
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = RBW_RESP_OKAY;
      d.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        RBW_CTRL_OFS: begin
          d.rdata[RBW_CTRL_W-1:0] = q.ctrl;
        end
        RBW_STAT_OFS: begin
          d.rdata[RBW_CTRL_W-1:0] = stat_word;
        end
        RBW_IRQ_STAT_OFS: begin
          d.rdata[RBW_EV_W-1:0] = q.ev_stat;
        end
        RBW_IRQ_EN_OFS: begin
          d.rdata[RBW_EV_W-1:0] = q.ev_en;
        end
        RBW_IRQ_CLR_OFS: begin
          d.rresp = RBW_RESP_OKAY;
        end
        default: begin
          d.rresp = RBW_RESP_SLVERR;
        end
      endcase
    end
    d.arready = !d.rvalid;

    // Heartbeat supervision.
    d.hb_prev = q.ctrl[RBW_HB_BIT];
    hb_changed = q.ctrl[RBW_HB_BIT] != q.hb_prev;
    if (hb_changed) begin
      d.count = '0; // R09
      d.tripped = 1'b0; // R09
      ev_set[RBW_EV_RESUME] = q.tripped;
    end else if (q.count >= TIMEOUT_CYC - 30'h1) begin
      d.tripped = 1'b1; // R02
      ev_set[RBW_EV_TRIP] = !q.tripped;
    end else begin
      d.count = q.count + 30'h1;
    end

    // Forced-off state gates valves, UV and heaters but never the pump.
    d.drive = q.ctrl;
    d.drive[RBW_HB_BIT] = q.ctrl[RBW_HB_BIT];
    if (d.tripped) begin
      d.drive[RBW_SPAN_BIT] = 1'b0; // R02
      d.drive[RBW_CAL_BIT] = 1'b0; // R02
      d.drive[RBW_UV_BIT] = 1'b0; // R03
      d.drive[RBW_CHAMBER_BIT] = 1'b0; // R03
      d.drive[RBW_PERM_BIT] = 1'b0; // R03
    end
    d.drive[RBW_PUMP_BIT] = q.ctrl[RBW_PUMP_BIT]; // R04

    // A new event wins over a clear in the same cycle.
    d.ev_stat = (q.ev_stat & ~ev_clr) | ev_set;
    d.irq = |(d.ev_stat & d.ev_en);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q <= RBW_STATE_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; each indicator shares the flop of the drive it shows.
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign heartbeat_indicator = q.drive[RBW_HB_BIT];
  assign chamber_heater_on = q.drive[RBW_CHAMBER_BIT];
  assign perm_heater_on = q.drive[RBW_PERM_BIT];
  assign zero_span_valve_drv = q.drive[RBW_SPAN_BIT];
  assign sample_cal_valve_drv = q.drive[RBW_CAL_BIT];
  assign uv_source_on = q.drive[RBW_UV_BIT];
  assign pump_on = q.drive[RBW_PUMP_BIT];
  assign chamber_heat_indicator = q.drive[RBW_CHAMBER_BIT]; // R05
  assign perm_tube_heat_indicator = q.drive[RBW_PERM_BIT]; // R05
  assign zero_span_valve_indicator = q.drive[RBW_SPAN_BIT]; // R06
  assign sample_cal_valve_indicator = q.drive[RBW_CAL_BIT]; // R07
  assign watchdog_tripped = q.tripped;
  assign irq = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking rbw_cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  valves_closed_a: // R02
  assert property (watchdog_tripped |->
    !zero_span_valve_drv && !sample_cal_valve_drv)
    else $error("valve driven while tripped");

  trip_on_time_a: // R02
  assert property (q.count == TIMEOUT_CYC - 30'h1 && !hb_changed
    |=> watchdog_tripped)
    else $error("watchdog did not trip at timeout");

  uv_heat_off_a: // R03
  assert property (watchdog_tripped |->
    !uv_source_on && !chamber_heater_on && !perm_heater_on)
    else $error("UV or heater on while tripped");

  pump_kept_a: // R04
  assert property (watchdog_tripped && $past(q.ctrl[RBW_PUMP_BIT])
    |-> pump_on)
    else $error("pump stopped by watchdog");

  heat_indicator_a: // R05
  assert property (chamber_heat_indicator == chamber_heater_on &&
    perm_tube_heat_indicator == perm_heater_on)
    else $error("heater indicator mismatch");

  chamber_ind_a: // R05
  assert property (##1 chamber_heat_indicator ==
    ($past(q.ctrl[RBW_CHAMBER_BIT]) && !watchdog_tripped))
    else $error("chamber heater indicator wrong");

  perm_ind_a: // R05
  assert property (##1 perm_tube_heat_indicator ==
    ($past(q.ctrl[RBW_PERM_BIT]) && !watchdog_tripped))
    else $error("permeation heater indicator wrong");

  span_indicator_a: // R06
  assert property (##1 zero_span_valve_indicator ==
    ($past(q.ctrl[RBW_SPAN_BIT]) && !watchdog_tripped))
    else $error("zero span indicator wrong");

  cal_indicator_a: // R07
  assert property (##1 sample_cal_valve_indicator ==
    ($past(q.ctrl[RBW_CAL_BIT]) && !watchdog_tripped))
    else $error("sample cal indicator wrong");

  bresp_hold_a: // R08
  assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

  rdata_hold_a: // R08
  assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");

  restart_count_a: // R09
  assert property (hb_changed |=> q.count == 30'h0 && !watchdog_tripped)
    else $error("heartbeat toggle did not restart count");

endmodule

// ### dv/rbw_host.sv
// Host model: AXI4-Lite master making one register access at a time.
// Assumes a single caller; only the bench timeout ends a wait.
`timescale 1ns/1ns
module rbw_host (
  input wire logic core_clk,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [4:0] s_axi_awaddr,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  output logic [4:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 42'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Released payloads are inverted so a stale value is never mistaken.
  // Response ready rises only once the answer shows, so the slave must hold.
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge core_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    while (!(ta && tw)) begin
      @(posedge core_clk);
      if (!ta && s_axi_awready) begin
        ta = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (!tw && s_axi_wready) begin
        tw = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    while (!s_axi_bvalid) @(posedge core_clk);
    s_axi_bready <= 1'b1;
    @(posedge core_clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge core_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    while (!s_axi_rvalid) @(posedge core_clk);
    s_axi_rready <= 1'b1;
    @(posedge core_clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// ### dv/relay_board_heartbeat_watchdog_tb_top.sv
// Bench top: register-level tests of the heartbeat watchdog.
// Assumes a short timeout parameter so a trip happens within the run.
`timescale 1ns/1ns
module relay_board_heartbeat_watchdog_tb_top;
  import rbw_pkg::*;
  localparam logic [29:0] TO_CYC = 30'h32;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, ind;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic heartbeat_indicator, chamber_heater_on, perm_heater_on;
  logic zero_span_valve_drv, sample_cal_valve_drv, uv_source_on, pump_on;
  logic chamber_heat_indicator, perm_tube_heat_indicator;
  logic zero_span_valve_indicator, sample_cal_valve_indicator;
  logic watchdog_tripped, irq;
  logic [6:0] drv;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  assign drv = {pump_on, uv_source_on, sample_cal_valve_drv,
    zero_span_valve_drv, perm_heater_on, chamber_heater_on,
    heartbeat_indicator};
  assign ind = {sample_cal_valve_indicator, zero_span_valve_indicator,
    perm_tube_heat_indicator, chamber_heat_indicator};

  initial begin
    forever #20 core_clk = ~core_clk;
  end

  rbw_watchdog #(.TIMEOUT_CYC(TO_CYC)) uut (
    .core_clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .heartbeat_indicator, .chamber_heater_on,
    .perm_heater_on, .zero_span_valve_drv, .sample_cal_valve_drv,
    .uv_source_on, .pump_on, .chamber_heat_indicator,
    .perm_tube_heat_indicator, .zero_span_valve_indicator,
    .sample_cal_valve_indicator, .watchdog_tripped, .irq);

  rbw_host host (
    .core_clk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // The tests need well under 1000 cycles; this cuts a hang short.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      error_cnt++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    chk("drv_rst", 32'h0, 32'(drv));
    host.wr(RBW_IRQ_EN_OFS, 32'h3, r);
    chk("bresp_en", 32'(RBW_RESP_OKAY), 32'(r));
    host.wr(RBW_CTRL_OFS, 32'h7E, r);
    chk("bresp", 32'(RBW_RESP_OKAY), 32'(r));
    repeat (3) @(posedge core_clk);
    chk("drv_on", 32'h7E, 32'(drv));
    chk("ind_on", 32'hF, 32'(ind));
    $display("test drive done");
    for (int i = 1; i <= 4; i++) begin
      host.wr(RBW_CTRL_OFS, 32'h7E | 32'(i % 2), r);
      repeat (TO_CYC / 2) @(posedge core_clk);
      chk("hb_run", 32'h0, 32'(watchdog_tripped));
    end
    repeat (TO_CYC) @(posedge core_clk);
    chk("drv_trip", 32'h40, 32'(drv));
    chk("ind_trip", 32'h0, 32'(ind));
    chk("irq_trip", 32'h1, 32'(irq));
    host.rd(RBW_STAT_OFS, d, r);
    chk("stat_trip", 32'h41, d);
    chk("rresp", 32'(RBW_RESP_OKAY), 32'(r));
    host.rd(RBW_IRQ_STAT_OFS, d, r);
    chk("irq_stat", 32'h1, d);
    host.wr(RBW_IRQ_CLR_OFS, 32'h1, r);
    repeat (2) @(posedge core_clk);
    chk("irq_clr", 32'h0, 32'(irq));
    chk("trip_held", 32'h1, 32'(watchdog_tripped));
    $display("test trip done");
    host.wr(RBW_CTRL_OFS, 32'h7F, r);
    repeat (3) @(posedge core_clk);
    chk("resume", 32'h0, 32'(watchdog_tripped));
    chk("drv_back", 32'h7F, 32'(drv));
    host.rd(RBW_IRQ_STAT_OFS, d, r);
    chk("irq_res", 32'h2, d);
    host.wr(RBW_IRQ_EN_OFS, 32'h0, r);
    repeat (2) @(posedge core_clk);
    chk("irq_mask", 32'h0, 32'(irq));
    host.rd(5'h14, d, r);
    chk("bad_resp", 32'(RBW_RESP_SLVERR), 32'(r));
    chk("bad_data", 32'h0, d);
    $display("test irq and bus done");
    results();
  end
endmodule
